// [src/flpm_defs.svh]
// register offsets, field positions, reset values and timing constants
`ifndef FLPM_DEFS_SVH
`define FLPM_DEFS_SVH

// byte addresses of the registers
`define FLPM_OFS_RX_LEVEL 8'h7c
`define FLPM_OFS_TX_LEVEL 8'h80
`define FLPM_OFS_PWR_CTRL 8'h84
`define FLPM_OFS_BYTE_TEST 8'h60

// level register fields
`define FLPM_LVL_WORDS_LSB 16
`define FLPM_RST_WORDS 8'h00
`define FLPM_RST_RX_BYTES 16'h0000
`define FLPM_RST_TX_FREE 16'h1200

// power control fields
`define FLPM_POWER_STATE_SELECT_HI 13
`define FLPM_POWER_STATE_SELECT_LO 12
`define FLPM_BIT_TRANSCEIVER_RESET 10
`define FLPM_BIT_FRAME_EN 9
`define FLPM_BIT_ENERGY_DETECT_ENABLE 8
`define FLPM_BIT_BUF_KIND 6
`define FLPM_BIT_WS_FRAME 5
`define FLPM_BIT_WS_ED 4
`define FLPM_BIT_PULSE 3
`define FLPM_BIT_POL 2
`define FLPM_BIT_OUT_EN 1
`define FLPM_BIT_READY 0
`define FLPM_MODE_FULL 2'h0
`define FLPM_MODE_LOW 2'h1
`define FLPM_MODE_DEEP 2'h2

// timing
`define FLPM_CLK_MHZ 125
`define FLPM_TRANSCEIVER_RESET_US 100
`define FLPM_PULSE_MS 50
`define FLPM_READY_CYCLES 16

`endif

// [src/flpm_pkg.sv]
// types shared by the fifo level and power control register slice
package flpm_pkg;

  // power sequencing states
  typedef enum logic [1:0] {
    FLPM_RUN,
    FLPM_ASLEEP,
    FLPM_WAKING
  } flpm_state_t;

endpackage

// [src/flpm_csr.sv]
// fifo level and power management register slice of the ethernet controller
//
// Operation
// R1 - rx status fifo words used, bits 23-16
// R2 - rx data bytes used, rounded frame add
// R3 - tx status fifo words used, bits 23-16
// R4 - tx data bytes free, reset 1200h
// R5 - host never overfills the tx data fifo
// R6 - power control readable in any state
// R7 - writes ignored until first read
// R8 - decode power mode field, bits 13-12
// R9 - byte test write wakes the device
// R10 - host writes only byte test when unready
// R11 - self-timed transceiver reset, at least 100us
// R12 - transceiver reset bit write ignored while set
// R13 - wake frame event drives output and interrupt
// R14 - energy detect event drives output and interrupt
// R15 - buffer kind selects open-drain or push-pull
// R16 - soft reset reinitialises all but kept bits; the transceiver reset bit is also left as it is
// R17 - ready bit, other addresses invalid until set
// R18 - pulse mode gives 50ms pulse, else level
// R19 - output enable gates only external output
// R20 - reserved bits read zero, ignore writes
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps

`include "flpm_defs.svh"

module flpm_csr
  import flpm_pkg::*;
#(
  parameter int TRANSCEIVER_RESET_CYCLES = `FLPM_TRANSCEIVER_RESET_US * `FLPM_CLK_MHZ,
  parameter int PULSE_CYCLES = `FLPM_PULSE_MS * 1000 * `FLPM_CLK_MHZ,
  parameter int READY_CYCLES = `FLPM_READY_CYCLES
) (
  input wire logic ref_clk_i, // system clock, 125 MHz
  input wire logic resetn_i, // asynchronous reset, active low
  input wire logic soft_reset_i, // soft reset pulse
  input wire logic [7:0] addr_i, // register byte address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after read strobe
  input wire logic rx_status_push_i, // one status word enters rx status fifo
  input wire logic rx_status_pop_i, // one status word leaves rx status fifo
  input wire logic rx_frame_push_i, // received frame written to rx data fifo
  input wire logic [15:0] rx_frame_len_i, // its length in bytes
  input wire logic rx_data_pop_i, // one word read out of rx data fifo
  input wire logic tx_status_push_i, // one status word enters tx status fifo
  input wire logic tx_status_pop_i, // one status word leaves tx status fifo
  input wire logic tx_data_push_i, // host wrote one word into tx data fifo
  input wire logic tx_data_release_i, // transmitted bytes released
  input wire logic [15:0] tx_release_bytes_i, // count released
  input wire logic wake_frame_event_i, // wake frame detected pulse
  input wire logic energy_detect_event_i, // energy detected pulse
  output logic [1:0] power_state_select_o, // active power mode code
  output logic device_ready_o, // device ready
  output logic transceiver_reset_o, // transceiver reset, active high
  output logic wake_interrupt_o, // internal wake interrupt level
  output logic wake_event_o, // wake pin output value
  output logic wake_event_oe_n_o // wake pin output enable, active low
);

  localparam logic [23:0] PHY_LOAD = 24'(TRANSCEIVER_RESET_CYCLES - 1);
  localparam logic [23:0] PULSE_LOAD = 24'(PULSE_CYCLES);
  localparam logic [7:0] READY_LOAD = 8'(READY_CYCLES);

  // saturating update used by every level counter
  function automatic logic [15:0] flpm_step(input logic [15:0] val,
                                            input logic [15:0] add,
                                            input logic [15:0] sub);
    logic [16:0] sum;
    sum = {1'b0, val} + {1'b0, add};
    if (sum[16]) begin
      sum = 17'h0_ffff;
    end
    if (sub > sum[15:0]) begin
      flpm_step = 16'h0000;
    end else begin
      flpm_step = sum[15:0] - sub;
    end
  endfunction

  flpm_state_t state;
  flpm_state_t next_state;
  logic [1:0] pm_code;
  logic [7:0] ready_cnt;
  logic wr_armed;
  logic [7:0] rx_status_words_used;
  logic [15:0] rx_data_bytes_used;
  logic [7:0] tx_status_words_used;
  logic [15:0] tx_data_bytes_free;
  logic transceiver_reset;
  logic [23:0] phy_cnt;
  logic wake_frame_event_enable;
  logic energy_detect_enable;
  logic wake_output_buffer_kind;
  logic wake_output_polarity;
  logic wake_output_enable;
  logic wake_output_pulse_mode;
  logic [1:0] wake_status;
  logic [23:0] pulse_cnt;

  // address decode and write qualification
  wire ready = (state == FLPM_RUN);
  wire sel_rx = (addr_i == `FLPM_OFS_RX_LEVEL);
  wire sel_tx = (addr_i == `FLPM_OFS_TX_LEVEL);
  wire sel_pmc = (addr_i == `FLPM_OFS_PWR_CTRL);
  wire sel_test = (addr_i == `FLPM_OFS_BYTE_TEST);
  // R7 writes need read
  // R17 unready blocks writes
  wire wr_ok = wr_i && wr_armed && ready;
  wire pmc_wr = wr_ok && sel_pmc;
  // R9 byte test wakes
  wire wake_wr = wr_i && sel_test && (state == FLPM_ASLEEP);
  wire [1:0] mode_req = wdata_i[`FLPM_POWER_STATE_SELECT_HI:`FLPM_POWER_STATE_SELECT_LO];
  // R8 reserved code ignored
  wire sleep_req = pmc_wr &&
                   (mode_req == `FLPM_MODE_LOW || mode_req == `FLPM_MODE_DEEP);

  // level counter arithmetic
  // R2 round up to word
  wire [13:0] rx_len_words = rx_frame_len_i[15:2] + 14'(|rx_frame_len_i[1:0]);
  wire [15:0] rx_add = rx_frame_push_i ? {rx_len_words, 2'b00} : 16'h0000;
  wire [15:0] rx_sub = rx_data_pop_i ? 16'h0004 : 16'h0000;
  wire [15:0] tx_add = tx_data_release_i ? tx_release_bytes_i : 16'h0000;
  // R5 host stays within free space, count floors at zero
  wire [15:0] tx_sub = tx_data_push_i ? 16'h0004 : 16'h0000;
  wire [15:0] rxs_next = flpm_step({8'h00, rx_status_words_used},
                                   {15'h0000, rx_status_push_i},
                                   {15'h0000, rx_status_pop_i});
  wire [15:0] txs_next = flpm_step({8'h00, tx_status_words_used},
                                   {15'h0000, tx_status_push_i},
                                   {15'h0000, tx_status_pop_i});

  // wake event capture
  // R13 frame event enable
  // R14 energy event enable
  wire [1:0] ws_set = {wake_frame_event_i && wake_frame_event_enable,
                       energy_detect_event_i && energy_detect_enable};
  wire [1:0] ws_clr = pmc_wr ? wdata_i[`FLPM_BIT_WS_FRAME:`FLPM_BIT_WS_ED] : 2'b00;
  wire [1:0] next_wake_status = (wake_status & ~ws_clr) | ws_set;

  // R18 pulse or level
  // R19 enable gates pin only
  wire wake_active = wake_output_enable &&
                     (wake_output_pulse_mode ? (|pulse_cnt && |wake_status) : |wake_status);

  // R15 open-drain drives low only
  wire next_pin = wake_output_buffer_kind ?
                  (wake_output_polarity ? wake_active : !wake_active) : 1'b0;
  wire next_pin_oe_n = wake_output_buffer_kind ? 1'b0 : !wake_active;

  // power sequencing next state
  always_comb begin
    next_state = state;
    case (state)
      FLPM_RUN: begin
        // R8 enter reduced power
        if (sleep_req) begin
          next_state = FLPM_ASLEEP;
        end
      end
      FLPM_ASLEEP: begin
        if (wake_wr) begin
          next_state = FLPM_WAKING;
        end
      end
      FLPM_WAKING: begin
        if (ready_cnt == 8'h00) begin
          next_state = FLPM_RUN;
        end
      end
      default: begin
        next_state = FLPM_WAKING;
      end
    endcase
    if (soft_reset_i) begin
      next_state = FLPM_WAKING;
    end
  end

  // power state, mode code and wake-up settle counter
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= FLPM_WAKING;
      pm_code <= `FLPM_MODE_FULL;
      ready_cnt <= READY_LOAD;
    end else begin
      state <= next_state;
      if (next_state == FLPM_ASLEEP && state == FLPM_RUN) begin
        pm_code <= mode_req;
      end else if (next_state != FLPM_ASLEEP) begin
        pm_code <= `FLPM_MODE_FULL;
      end
      if (next_state == FLPM_WAKING && state != FLPM_WAKING) begin
        ready_cnt <= READY_LOAD;
      end else if (ready_cnt != 8'h00) begin
        ready_cnt <= ready_cnt - 8'h01;
      end
    end
  end

  // write arming: cleared by reset and wake, set by any read
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_armed <= 1'b0;
    end else begin
      // R7 re-arm after wake
      if (soft_reset_i || wake_wr) begin
        wr_armed <= 1'b0;
      end else if (rd_i) begin
        wr_armed <= 1'b1;
      end
    end
  end

  // fifo level counters
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_status_words_used <= `FLPM_RST_WORDS;
      rx_data_bytes_used <= `FLPM_RST_RX_BYTES;
      tx_status_words_used <= `FLPM_RST_WORDS;
      tx_data_bytes_free <= `FLPM_RST_TX_FREE;
    end else if (soft_reset_i) begin
      // R16 soft reset levels
      rx_status_words_used <= `FLPM_RST_WORDS;
      rx_data_bytes_used <= `FLPM_RST_RX_BYTES;
      tx_status_words_used <= `FLPM_RST_WORDS;
      tx_data_bytes_free <= `FLPM_RST_TX_FREE;
    end else begin
      // R1 rx status words
      rx_status_words_used <= rxs_next[7:0];
      // R2 rx data bytes
      rx_data_bytes_used <= flpm_step(rx_data_bytes_used, rx_add, rx_sub);
      // R3 tx status words
      tx_status_words_used <= txs_next[7:0];
      // R4 tx free bytes
      tx_data_bytes_free <= flpm_step(tx_data_bytes_free, tx_add, tx_sub);
    end
  end

  // self-timed transceiver reset
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      transceiver_reset <= 1'b0;
      phy_cnt <= 24'h00_0000;
    end else if (transceiver_reset) begin
      // R11 hold then release
      if (phy_cnt == 24'h00_0000) begin
        transceiver_reset <= 1'b0;
      end else begin
        phy_cnt <= phy_cnt - 24'h00_0001;
      end
    // R12 ignored while set
    end else if (pmc_wr && wdata_i[`FLPM_BIT_TRANSCEIVER_RESET]) begin
      transceiver_reset <= 1'b1;
      phy_cnt <= PHY_LOAD;
    end
  end

  // writable control bits; buffer kind and polarity survive soft reset
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_frame_event_enable <= 1'b0;
      energy_detect_enable <= 1'b0;
      wake_output_pulse_mode <= 1'b0;
      wake_output_enable <= 1'b0;
      wake_output_buffer_kind <= 1'b0;
      wake_output_polarity <= 1'b0;
    end else if (soft_reset_i) begin
      // R16 kept bits untouched
      wake_frame_event_enable <= 1'b0;
      energy_detect_enable <= 1'b0;
      wake_output_pulse_mode <= 1'b0;
      wake_output_enable <= 1'b0;
    end else if (pmc_wr) begin
      // R20 only defined bits stored
      wake_frame_event_enable <= wdata_i[`FLPM_BIT_FRAME_EN];
      energy_detect_enable <= wdata_i[`FLPM_BIT_ENERGY_DETECT_ENABLE];
      wake_output_pulse_mode <= wdata_i[`FLPM_BIT_PULSE];
      wake_output_enable <= wdata_i[`FLPM_BIT_OUT_EN];
      // R15 buffer kind
      wake_output_buffer_kind <= wdata_i[`FLPM_BIT_BUF_KIND];
      wake_output_polarity <= wdata_i[`FLPM_BIT_POL];
    end
  end

  // wake status, set wins over write-one-to-clear
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_status <= 2'b00;
    end else if (soft_reset_i) begin
      wake_status <= ws_set;
    end else begin
      wake_status <= next_wake_status;
    end
  end

  // pulse timer for the wake pin
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_cnt <= 24'h00_0000;
    end else if (|ws_set) begin
      // R18 pulse restart
      pulse_cnt <= PULSE_LOAD;
    end else if (pulse_cnt != 24'h00_0000) begin
      pulse_cnt <= pulse_cnt - 24'h00_0001;
    end
  end

  // registered pin drive and status outputs
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_event_o <= 1'b0;
      wake_event_oe_n_o <= 1'b1;
    end else begin
      wake_event_o <= next_pin;
      wake_event_oe_n_o <= next_pin_oe_n;
    end
  end

  assign power_state_select_o = pm_code;
  assign device_ready_o = ready;
  assign transceiver_reset_o = transceiver_reset;
  // R13 interrupt independent of pin
  // R14 interrupt independent of pin
  assign wake_interrupt_o = |wake_status;

  // read data words, reserved bits zero
  // R20 reserved read zero
  wire [31:0] rx_word = {8'h00, rx_status_words_used, rx_data_bytes_used};
  wire [31:0] tx_word = {8'h00, tx_status_words_used, tx_data_bytes_free};
  wire [31:0] pmc_word = {18'h0_0000, pm_code, 1'b0, transceiver_reset,
                          wake_frame_event_enable, energy_detect_enable, 1'b0,
                          wake_output_buffer_kind, wake_status, wake_output_pulse_mode,
                          wake_output_polarity, wake_output_enable, ready};
  // R6 power control always readable
  // R17 others read zero until ready
  wire [31:0] rd_mux = sel_pmc ? pmc_word :
                       (ready && sel_rx) ? rx_word :
                       (ready && sel_tx) ? tx_word : 32'h0000_0000;

  // read data register, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // flpm_csr

// [sim/flpm_csr_properties.sv]
// port-level assertions for the fifo level and power register slice
`timescale 1ns/100ps
module flpm_csr_props
  import flpm_pkg::*;
#(
  parameter int TRANSCEIVER_RESET_CYCLES = 20
) (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic soft_reset_i, // soft reset pulse
  input wire logic [7:0] addr_i, // address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [31:0] rdata_o, // read data
  input wire logic wake_frame_event_i, // frame event
  input wire logic energy_detect_event_i, // energy event
  input wire logic [1:0] power_state_select_o, // mode
  input wire logic device_ready_o, // ready
  input wire logic transceiver_reset_o, // transceiver reset
  input wire logic wake_interrupt_o // wake interrupt
);
  logic armed;
  logic next_armed;
  int hold;
  int next_hold;
  wire logic pwr_wr = wr_i && addr_i == 8'h84 && armed && device_ready_o && !soft_reset_i;
  // byte test write while asleep, which drops the write arm
  wire logic wake_wr = wr_i && addr_i == 8'h60 && !device_ready_o &&
                       power_state_select_o != 2'h0;
  // writes count as armed once any read was seen since reset, soft reset or wake
  assign next_armed = !soft_reset_i && !wake_wr && (armed || rd_i);
  assign next_hold = transceiver_reset_o ? hold + 1 : 0;
  // arm tracker and transceiver reset length counter
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed <= 1'b0;
      hold <= 0;
    end else begin
      armed <= next_armed;
      hold <= next_hold;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_rd_pmc;
    rd_i && addr_i == 8'h84 |=> rdata_o[13:12] == $past(power_state_select_o)
      && rdata_o[10] == $past(transceiver_reset_o) && rdata_o[0] == $past(device_ready_o)
      && rdata_o[31:14] == 18'h0_0000 && !rdata_o[11] && !rdata_o[7];
  endproperty
  a_rd_pmc: assert property (p_rd_pmc) else $error("power word read wrong");
  property p_rsv;
    rd_i |=> rdata_o[31:24] == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_sleep;
    pwr_wr && wdata_i[13] != wdata_i[12] |=> !device_ready_o && power_state_select_o != 2'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("power mode not entered");
  property p_mode_rsv;
    pwr_wr && wdata_i[13:12] == 2'h3 |=> device_ready_o && power_state_select_o == 2'h0;
  endproperty
  a_mode_rsv: assert property (p_mode_rsv) else $error("reserved mode accepted");
  property p_wake;
    !device_ready_o && power_state_select_o != 2'h0 && wr_i && addr_i == 8'h60
      |=> power_state_select_o == 2'h0 ##[1:20] device_ready_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on byte test write");
  property p_unarmed;
    wr_i && addr_i == 8'h84 && !armed && device_ready_o && wdata_i[13:12] == 2'h1
      |=> device_ready_o;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("write taken before a read");
  property p_phy_set;
    pwr_wr && wdata_i[10] && !transceiver_reset_o |=> transceiver_reset_o;
  endproperty
  a_phy_set: assert property (p_phy_set) else $error("transceiver reset not set");
  property p_phy_min;
    $fell(transceiver_reset_o) |-> hold >= TRANSCEIVER_RESET_CYCLES - 1;
  endproperty
  a_phy_min: assert property (p_phy_min) else $error("transceiver reset too short");
  property p_phy_len;
    transceiver_reset_o |-> hold <= TRANSCEIVER_RESET_CYCLES + 1;
  endproperty
  a_phy_len: assert property (p_phy_len) else $error("transceiver reset too long");
  property p_int;
    $rose(wake_interrupt_o) |-> $past(wake_frame_event_i) || $past(energy_detect_event_i)
      || $past(wake_frame_event_i, 2) || $past(energy_detect_event_i, 2);
  endproperty
  a_int: assert property (p_int) else $error("interrupt without event");
  c_sleep: cover property (pwr_wr && wdata_i[13:12] == 2'h1);
  c_phy: cover property ($fell(transceiver_reset_o));
  c_int: cover property ($rose(wake_interrupt_o));
endmodule // flpm_csr_props

bind flpm_csr flpm_csr_props #(.TRANSCEIVER_RESET_CYCLES(TRANSCEIVER_RESET_CYCLES)) i_flpm_csr_props (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .wake_frame_event_i(wake_frame_event_i), .energy_detect_event_i(energy_detect_event_i),
  .power_state_select_o(power_state_select_o), .device_ready_o(device_ready_o),
  .transceiver_reset_o(transceiver_reset_o), .wake_interrupt_o(wake_interrupt_o));

// [sim/flpm_host.sv]
// host processor model driving the register port
`timescale 1ns/100ps
module flpm_host
  import flpm_pkg::*;
(
  input wire logic clk_i, // system clock
  output logic [7:0] addr_o, // address
  output logic [31:0] wdata_o, // write data
  output logic wr_o, // write strobe
  output logic rd_o // read strobe
);
  logic [31:0] exp_q[$];
  // idle bus at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // callers keep pushes within free space and only byte test writes while unready
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // one read cycle, noting the expected answer
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
  endtask
endmodule // flpm_host

// [sim/fifo_level_and_power_mgmt_csr_test.sv]
// self-checking bench for the fifo level and power register slice
`timescale 1ns/100ps
module fifo_level_and_power_mgmt_csr_test
  import flpm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [10:0] pl = '0;
  logic [15:0] len = 16'h0000;
  logic [15:0] rel = 16'h0000;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [31:0] x = 32'h007a_9240;
  logic wr, rd, rdy, trst, wint, wev, wev_oe_n;
  logic rd_seen = 1'b0;
  logic [1:0] mode;
  logic [31:0] cfg [4] = '{32'h0000_0342, 32'h0000_0302, 32'h0000_0340, 32'h0000_034e};
  logic [2:0] act [4] = '{3'b100, 3'b100, 3'b110, 3'b110};
  logic [2:0] idle [4] = '{3'b010, 3'b001, 3'b010, 3'b000};
  int err_total = 0, n_compared = 0, cyc = 0, rs = 0, rb = 0, ts = 0, tf = 4608;
  always #4 clk = ~clk;
  flpm_csr #(.TRANSCEIVER_RESET_CYCLES(20), .PULSE_CYCLES(30), .READY_CYCLES(2)) i_flpm_csr (
    .ref_clk_i(clk), .resetn_i(rst_n), .soft_reset_i(pl[10]), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_status_push_i(pl[0]), .rx_status_pop_i(pl[1]),
    .rx_frame_push_i(pl[2]), .rx_frame_len_i(len), .rx_data_pop_i(pl[3]),
    .tx_status_push_i(pl[4]), .tx_status_pop_i(pl[5]), .tx_data_push_i(pl[6]),
    .tx_data_release_i(pl[7]), .tx_release_bytes_i(rel), .wake_frame_event_i(pl[8]),
    .energy_detect_event_i(pl[9]), .power_state_select_o(mode), .device_ready_o(rdy),
    .transceiver_reset_o(trst), .wake_interrupt_o(wint), .wake_event_o(wev),
    .wake_event_oe_n_o(wev_oe_n));
  flpm_host i_flpm_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task pls(input int b);
    @(posedge clk);
    pl[b] <= 1'b1;
    @(posedge clk);
    pl <= '0;
  endtask
  task wait_rdy;
    @(posedge clk);
    for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(posedge clk);
    #1 check(rdy, 1);
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // read answers against the oldest note, plus the hang limit
  always @(posedge clk) begin
    rd_seen <= rd;
    cyc <= cyc + 1;
    if (rd_seen === 1'b1) check(rdata, i_flpm_host.exp_q.pop_front());
    if (cyc == 5000) begin
      err_total++;
      conclude;
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wait_rdy;
    i_flpm_host.wr(8'h84, 32'h0000_1342);
    i_flpm_host.rd(8'h7c, 32'h0000_0000);
    i_flpm_host.rd(8'h80, 32'h0000_1200);
    i_flpm_host.rd(8'h84, 32'h0000_0001);
    i_flpm_host.rd(8'h40, 32'h0000_0000);
    i_flpm_host.wr(8'h84, cfg[0]);
    i_flpm_host.rd(8'h84, 32'h0000_0343);
    for (int i = 0; i < 6; i++) begin
      x = xs(x);
      len <= {5'h00, x[10:0]};
      rb += (int'(x[10:0]) + 3) / 4 * 4;
      pls(2);
      pls(0);
      rs++;
      pls(4);
      ts++;
      pls(6);
      tf -= 4;
    end
    pls(1);
    pls(3);
    pls(5);
    rel <= 16'h0008;
    pls(7);
    i_flpm_host.rd(8'h7c, {8'h00, 8'(rs - 1), 16'(rb - 4)});
    i_flpm_host.rd(8'h80, {8'h00, 8'(ts - 1), 16'(tf + 8)});
    i_flpm_host.wr(8'h84, 32'h0000_0742);
    #1 check(trst, 1);
    i_flpm_host.wr(8'h84, 32'h0000_0742);
    for (int i = 0; i < 60 && trst !== 1'b0; i++) @(posedge clk);
    i_flpm_host.rd(8'h84, 32'h0000_0343);
    for (int k = 0; k < 4; k++) begin
      i_flpm_host.wr(8'h84, cfg[k]);
      pls(k == 1 ? 9 : 8);
      @(posedge clk);
      #1 check({wint, wev, wev_oe_n}, act[k]);
      // pulse mode: pin drops once the pulse time has run out
      if (k == 3) begin
        repeat (40) @(posedge clk);
        #1 check({wint, wev, wev_oe_n}, 3'b100);
      end
      i_flpm_host.rd(8'h84, cfg[k] | (k == 1 ? 32'h0000_0011 : 32'h0000_0021));
      i_flpm_host.wr(8'h84, cfg[k] | (k == 1 ? 32'h0000_0010 : 32'h0000_0020));
      @(posedge clk);
      #1 check({wint, wev, wev_oe_n}, idle[k]);
    end
    for (int m = 1; m < 3; m++) begin
      i_flpm_host.wr(8'h84, 32'h0000_0340 | (m << 12));
      #1 check({rdy, mode}, {1'b0, 2'(m)});
      i_flpm_host.rd(8'h84, 32'h0000_0340 | (m << 12));
      i_flpm_host.wr(8'h60, x);
      wait_rdy;
      i_flpm_host.rd(8'h84, 32'h0000_0341);
    end
    i_flpm_host.wr(8'h84, 32'h0000_3340);
    i_flpm_host.rd(8'h84, 32'h0000_0341);
    i_flpm_host.wr(8'h84, 32'h0000_0346);
    pls(10);
    wait_rdy;
    i_flpm_host.rd(8'h84, 32'h0000_0045);
    i_flpm_host.rd(8'h80, 32'h0000_1200);
    repeat (3) @(posedge clk);
    conclude;
  end
endmodule // fifo_level_and_power_mgmt_csr_test
